// ---- common/cbd_pkg.sv ----
// constants and types shared by the conditional branch decoder
// How it works
// - not-equal branch taken when zero flag clear
// - carry set/lower on C=1, clear/same-higher on C=0
// - minus on N=1, plus on N=0
// - signed ge on N^V=0, lt on N^V=1
// - half carry set/clear branches test H
// - transfer bit set/clear branches test T
// - overflow set/clear branches test V
// - irq-on branch taken when I is 1
// - irq-off branch taken when I is 0
// - branches keep flags; one cycle, two if taken
// - register copy in one cycle, flags kept
package cbd_pkg;
  // status register bit positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;
  // operation codes presented on the decode port
  typedef enum logic [4:0] {
    CBD_OP_NOP                    = 5'h00,
    CBD_OP_BRANCH_UNEQUAL         = 5'h01,
    CBD_OP_BRANCH_CARRY_SET       = 5'h02,
    CBD_OP_BRANCH_CARRY_CLEAR     = 5'h03,
    CBD_OP_BRANCH_SAME_OR_HIGHER  = 5'h04,
    CBD_OP_BRANCH_LOWER           = 5'h05,
    CBD_OP_BRANCH_NEGATIVE        = 5'h06,
    CBD_OP_BRANCH_POSITIVE        = 5'h07,
    CBD_OP_BRANCH_SIGNED_GE       = 5'h08,
    CBD_OP_BRANCH_SIGNED_LT       = 5'h09,
    CBD_OP_BRANCH_HALFCARRY_SET   = 5'h0a,
    CBD_OP_BRANCH_HALFCARRY_CLEAR = 5'h0b,
    CBD_OP_BRANCH_TRANSFER_SET    = 5'h0c,
    CBD_OP_BRANCH_TRANSFER_CLEAR  = 5'h0d,
    CBD_OP_BRANCH_OVERFLOW_SET    = 5'h0e,
    CBD_OP_BRANCH_OVERFLOW_CLEAR  = 5'h0f,
    CBD_OP_BRANCH_IRQ_ON          = 5'h10,
    CBD_OP_BRANCH_IRQ_OFF         = 5'h11,
    CBD_OP_REGISTER_COPY          = 5'h12
  } cbd_op_t;
  // reset values
  localparam logic [7:0] SREG_RST = 8'h00;
  localparam logic [7:0] REG_RST  = 8'h00;
  // cycle counts
  localparam int unsigned BR_TAKEN_CYCLES = 2;
endpackage

// ---- logic/cbd_cond.sv ----
// branch condition evaluator
`timescale 1ns/1ps
`default_nettype none
module cbd_cond (
  input  wire logic             [4:0] op_i,
  input  wire logic             [7:0] sreg_i,
  output logic                        is_branch_o,
  output logic                        take_o
);
  import cbd_pkg::*;
  // pick the flag test for each branch form
  always_comb begin
    is_branch_o = 1'b1;
    take_o      = 1'b0;
    case (cbd_op_t'(op_i))
      CBD_OP_BRANCH_UNEQUAL:         take_o = ~sreg_i[FLAG_Z];
      CBD_OP_BRANCH_CARRY_SET,
      CBD_OP_BRANCH_LOWER:           take_o = sreg_i[FLAG_C];
      CBD_OP_BRANCH_CARRY_CLEAR,
      CBD_OP_BRANCH_SAME_OR_HIGHER:  take_o = ~sreg_i[FLAG_C];
      CBD_OP_BRANCH_NEGATIVE:        take_o = sreg_i[FLAG_N];
      CBD_OP_BRANCH_POSITIVE:        take_o = ~sreg_i[FLAG_N];
      CBD_OP_BRANCH_SIGNED_GE:       take_o = ~(sreg_i[FLAG_N] ^ sreg_i[FLAG_V]);
      CBD_OP_BRANCH_SIGNED_LT:       take_o = sreg_i[FLAG_N] ^ sreg_i[FLAG_V];
      CBD_OP_BRANCH_HALFCARRY_SET:   take_o = sreg_i[FLAG_H];
      CBD_OP_BRANCH_HALFCARRY_CLEAR: take_o = ~sreg_i[FLAG_H];
      CBD_OP_BRANCH_TRANSFER_SET:    take_o = sreg_i[FLAG_T];
      CBD_OP_BRANCH_TRANSFER_CLEAR:  take_o = ~sreg_i[FLAG_T];
      CBD_OP_BRANCH_OVERFLOW_SET:    take_o = sreg_i[FLAG_V];
      CBD_OP_BRANCH_OVERFLOW_CLEAR:  take_o = ~sreg_i[FLAG_V];
      CBD_OP_BRANCH_IRQ_ON:          take_o = sreg_i[FLAG_I];
      CBD_OP_BRANCH_IRQ_OFF:         take_o = ~sreg_i[FLAG_I];
      default:                       is_branch_o = 1'b0;
    endcase
  end
endmodule // cbd_cond
`default_nettype wire

// ---- logic/cbd_core.sv ----
// branch and register copy execute stage
`timescale 1ns/1ps
`default_nettype none
module cbd_core #(
  parameter int unsigned PC_W  = 12,
  parameter int unsigned OFS_W = 7,
  parameter int unsigned NREG  = 32
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   valid_i,
  input  wire logic [4:0]             op_i,
  input  wire logic [OFS_W-1:0]       offset_i,
  input  wire logic [$clog2(NREG)-1:0] dest_i,
  input  wire logic [$clog2(NREG)-1:0] source_register_i,
  input  wire logic                   sreg_we_i,
  input  wire logic [7:0]             sreg_wdata_i,
  input  wire logic [$clog2(NREG)-1:0] rd_addr_i,
  output logic                        ready_o,
  output logic      [PC_W-1:0]        pc_o,
  output logic      [7:0]             sreg_o,
  output logic      [7:0]             rd_data_o,
  output logic                        taken_o,
  output logic                        done_o
);
  import cbd_pkg::*;
  localparam int unsigned AW = $clog2(NREG);

  // refuse shapes the logic cannot serve
  initial begin
    if (OFS_W < 2 || OFS_W > PC_W || NREG < 2) begin
      $error("cbd_core: bad parameters");
    end
  end

  typedef enum logic [0:0] {CBD_EXEC, CBD_FLUSH} cbd_state_t;

  // sign-extend the displacement to program counter width
  function automatic logic [PC_W-1:0] cbd_sext(input logic [OFS_W-1:0] k);
    cbd_sext = {{(PC_W-OFS_W){k[OFS_W-1]}}, k};
  endfunction

  cbd_state_t       state_ff;
  logic [PC_W-1:0]  pc_ff;
  logic [PC_W-1:0]  nxt_pc;
  logic [7:0]       sreg_ff;
  logic [7:0]       regs_ff [NREG];
  logic [7:0]       rd_data_ff;
  logic             taken_ff;
  logic             done_ff;
  logic             is_branch;
  logic             take;
  logic             accept;
  logic             is_copy;

  cbd_cond u_cond (
    .op_i        (op_i),
    .sreg_i      (sreg_ff),
    .is_branch_o (is_branch),
    .take_o      (take)
  );

  assign accept  = valid_i && (state_ff == CBD_EXEC);
  assign is_copy = cbd_op_t'(op_i) == CBD_OP_REGISTER_COPY;

  // next pc: incremented pc plus displacement when taken
  always_comb begin
    nxt_pc = pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
    if (accept && is_branch && take) begin
      nxt_pc = pc_ff + cbd_sext(offset_i) + {{(PC_W-1){1'b0}}, 1'b1};
    end
  end

  // taken branch spends a second cycle flushing
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= CBD_EXEC;
    end else begin
      case (state_ff)
        CBD_EXEC:  state_ff <= (accept && is_branch && take) ? CBD_FLUSH : CBD_EXEC;
        CBD_FLUSH: state_ff <= CBD_EXEC;
        default:   state_ff <= CBD_EXEC;
      endcase
    end
  end

  // program counter advances once per accepted instruction
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_ff <= '0;
    end else if (accept) begin
      pc_ff <= nxt_pc;
    end
  end

  // flags only change by the external write port, never by branch or copy
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sreg_ff <= SREG_RST;
    end else if (sreg_we_i) begin
      sreg_ff <= sreg_wdata_i;
    end
  end

  // register file; copy completes in the accepting cycle
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NREG; i++) begin
        regs_ff[i] <= REG_RST;
      end
    end else if (accept && is_copy) begin
      regs_ff[dest_i] <= regs_ff[source_register_i];
    end
  end

  // status outputs
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_ff <= REG_RST;
      taken_ff   <= 1'b0;
      done_ff    <= 1'b0;
    end else begin
      rd_data_ff <= regs_ff[rd_addr_i];
      taken_ff   <= accept && is_branch && take;
      done_ff    <= (accept && !(is_branch && take)) || (state_ff == CBD_FLUSH);
    end
  end

  assign ready_o   = state_ff == CBD_EXEC;
  assign pc_o      = pc_ff;
  assign sreg_o    = sreg_ff;
  assign rd_data_o = rd_data_ff;
  assign taken_o   = taken_ff;
  assign done_o    = done_ff;

  // taken branch blocks the next cycle
  property p_taken_stall;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && is_branch && take) |=> !ready_o ##1 ready_o;
  endproperty
  a_taken_stall: assert property (p_taken_stall) else $error("taken branch not two cycles");

  // untaken branch ready next cycle
  property p_untaken;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && is_branch && !take) |=> ready_o && done_o && !taken_o;
  endproperty
  a_untaken: assert property (p_untaken) else $error("untaken branch not one cycle");

  // taken target
  property p_target;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && is_branch && take) |=> pc_o == $past(pc_ff) + $past(cbd_sext(offset_i)) + 1'b1;
  endproperty
  a_target: assert property (p_target) else $error("wrong branch target");

  // fall through
  property p_fall;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && !(is_branch && take)) |=> pc_o == $past(pc_ff) + 1'b1;
  endproperty
  a_fall: assert property (p_fall) else $error("wrong fall-through pc");

  // flags kept without write
  property p_flags;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      !sreg_we_i |=> $stable(sreg_o);
  endproperty
  a_flags: assert property (p_flags) else $error("flags changed");

  // zero flag decides unequal branch
  property p_unequal;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_UNEQUAL) |=> taken_o == !$past(sreg_ff[FLAG_Z]);
  endproperty
  a_unequal: assert property (p_unequal) else $error("unequal branch wrong");

  // signed lt decision
  property p_lt;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_SIGNED_LT)
        |=> taken_o == ($past(sreg_ff[FLAG_N]) ^ $past(sreg_ff[FLAG_V]));
  endproperty
  a_lt: assert property (p_lt) else $error("signed lt wrong");

  // copy lands in one cycle
  property p_copy;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && is_copy) |=> regs_ff[$past(dest_i)] == $past(regs_ff[source_register_i]);
  endproperty
  a_copy: assert property (p_copy) else $error("copy wrong");

  // irq-off decision
  property p_irq;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_IRQ_OFF) |=> taken_o == !$past(sreg_ff[FLAG_I]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq-off branch wrong");

  // carry set and lower forms follow C
  property p_carry_set;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && (cbd_op_t'(op_i) == CBD_OP_BRANCH_CARRY_SET || cbd_op_t'(op_i) == CBD_OP_BRANCH_LOWER))
        |=> taken_o == $past(sreg_ff[FLAG_C]);
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry set branch wrong");

  // carry clear and same-or-higher forms follow not C
  property p_carry_clr;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && (cbd_op_t'(op_i) == CBD_OP_BRANCH_CARRY_CLEAR || cbd_op_t'(op_i) == CBD_OP_BRANCH_SAME_OR_HIGHER))
        |=> taken_o == !$past(sreg_ff[FLAG_C]);
  endproperty
  a_carry_clr: assert property (p_carry_clr) else $error("carry clear branch wrong");

  // minus form follows N
  property p_neg;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_NEGATIVE)
        |=> taken_o == $past(sreg_ff[FLAG_N]);
  endproperty
  a_neg: assert property (p_neg) else $error("minus branch wrong");

  // plus form follows not N
  property p_pos;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_POSITIVE)
        |=> taken_o == !$past(sreg_ff[FLAG_N]);
  endproperty
  a_pos: assert property (p_pos) else $error("plus branch wrong");

  // signed ge decision
  property p_ge;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_SIGNED_GE)
        |=> taken_o == !($past(sreg_ff[FLAG_N]) ^ $past(sreg_ff[FLAG_V]));
  endproperty
  a_ge: assert property (p_ge) else $error("signed ge wrong");

  // half carry set form
  property p_half_set;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_HALFCARRY_SET)
        |=> taken_o == $past(sreg_ff[FLAG_H]);
  endproperty
  a_half_set: assert property (p_half_set) else $error("half carry set branch wrong");

  // half carry clear form
  property p_half_clr;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_HALFCARRY_CLEAR)
        |=> taken_o == !$past(sreg_ff[FLAG_H]);
  endproperty
  a_half_clr: assert property (p_half_clr) else $error("half carry clear branch wrong");

  // transfer bit set form
  property p_tr_set;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_TRANSFER_SET)
        |=> taken_o == $past(sreg_ff[FLAG_T]);
  endproperty
  a_tr_set: assert property (p_tr_set) else $error("transfer set branch wrong");

  // transfer bit clear form
  property p_tr_clr;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_TRANSFER_CLEAR)
        |=> taken_o == !$past(sreg_ff[FLAG_T]);
  endproperty
  a_tr_clr: assert property (p_tr_clr) else $error("transfer clear branch wrong");

  // overflow set form
  property p_ovf_set;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_OVERFLOW_SET)
        |=> taken_o == $past(sreg_ff[FLAG_V]);
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow set branch wrong");

  // overflow clear form
  property p_ovf_clr;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_OVERFLOW_CLEAR)
        |=> taken_o == !$past(sreg_ff[FLAG_V]);
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow clear branch wrong");

  // irq-on form follows I
  property p_irq_on;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (accept && cbd_op_t'(op_i) == CBD_OP_BRANCH_IRQ_ON)
        |=> taken_o == $past(sreg_ff[FLAG_I]);
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq-on branch wrong");
endmodule // cbd_core
`default_nettype wire

// ---- sim/test_conditional_branch_decode.sv ----
// self-checking bench for the branch and register copy execute stage
`timescale 1ns/1ps
`default_nettype none
module test_conditional_branch_decode;
  import cbd_pkg::*;
  logic        clk_sys_i;
  logic        rst_b_i;
  logic        valid_i;
  logic [4:0]  op_i;
  logic [6:0]  offset_i;
  logic [4:0]  dest_i;
  logic [4:0]  source_register_i;
  logic        sreg_we_i;
  logic [7:0]  sreg_wdata_i;
  logic [4:0]  rd_addr_i;
  logic        ready_o;
  logic [11:0] pc_o;
  logic [7:0]  sreg_o;
  logic [7:0]  rd_data_o;
  logic        taken_o;
  logic        done_o;
  int          num_errors;
  int          n_tests;
  logic [7:0]  pats [6] = '{8'h00, 8'hff, 8'h0a, 8'h05, 8'ha4, 8'h59};
  logic [6:0]  ofss [3] = '{7'h7f, 7'h40, 7'h3f};

  cbd_core dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .valid_i(valid_i), .op_i(op_i),
    .offset_i(offset_i), .dest_i(dest_i), .source_register_i(source_register_i),
    .sreg_we_i(sreg_we_i), .sreg_wdata_i(sreg_wdata_i), .rd_addr_i(rd_addr_i),
    .ready_o(ready_o), .pc_o(pc_o), .sreg_o(sreg_o), .rd_data_o(rd_data_o),
    .taken_o(taken_o), .done_o(done_o));

  // 200 mhz core clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // one comparison, counted
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // branch condition worked out from the flag bits
  function automatic logic exp_take(input logic [4:0] op, input logic [7:0] f);
    case (op)
      5'h01: exp_take = !f[FLAG_Z];
      5'h02, 5'h05: exp_take = f[FLAG_C];
      5'h03, 5'h04: exp_take = !f[FLAG_C];
      5'h06: exp_take = f[FLAG_N];
      5'h07: exp_take = !f[FLAG_N];
      5'h08: exp_take = !(f[FLAG_N] ^ f[FLAG_V]);
      5'h09: exp_take = f[FLAG_N] ^ f[FLAG_V];
      5'h0a: exp_take = f[FLAG_H];
      5'h0b: exp_take = !f[FLAG_H];
      5'h0c: exp_take = f[FLAG_T];
      5'h0d: exp_take = !f[FLAG_T];
      5'h0e: exp_take = f[FLAG_V];
      5'h0f: exp_take = !f[FLAG_V];
      5'h10: exp_take = f[FLAG_I];
      5'h11: exp_take = !f[FLAG_I];
      default: exp_take = 1'b0;
    endcase
  endfunction

  // load flags, issue one branch, hold a nop into the refused cycle
  task automatic run_branch(input logic [4:0] op, input logic [7:0] f, input logic [6:0] ofs);
    logic [11:0] pc0;
    logic [11:0] tgt;
    logic        tk;
    tk = exp_take(op, f);
    @(posedge clk_sys_i);
    sreg_we_i    <= 1'b1;
    sreg_wdata_i <= f;
    @(posedge clk_sys_i);
    sreg_we_i <= 1'b0;
    valid_i   <= 1'b1;
    op_i      <= op;
    offset_i  <= ofs;
    #1 pc0 = pc_o;
    tgt = tk ? pc0 + {{5{ofs[6]}}, ofs} + 12'h001 : pc0 + 12'h001;
    @(posedge clk_sys_i);
    valid_i <= tk;
    op_i    <= CBD_OP_NOP;
    #1;
    chk("pc", pc_o, tgt);
    chk("taken", taken_o, tk);
    chk("done", done_o, !tk);
    chk("ready", ready_o, !tk);
    chk("flags", sreg_o, f);
    if (tk) begin
      @(posedge clk_sys_i);
      valid_i <= 1'b0;
      #1;
      chk("done2", done_o, 1'b1);
      chk("pc_hold", pc_o, tgt);
    end
  endtask

  // copy between two registers and peek the destination
  task automatic run_copy;
    logic [11:0] pc0;
    logic [7:0]  f;
    @(posedge clk_sys_i);
    valid_i           <= 1'b1;
    op_i              <= CBD_OP_REGISTER_COPY;
    dest_i            <= 5'h1f;
    source_register_i <= 5'h00;
    rd_addr_i         <= 5'h1f;
    #1 pc0 = pc_o;
    f = sreg_o;
    @(posedge clk_sys_i);
    valid_i <= 1'b0;
    #1;
    chk("copy_done", done_o, 1'b1);
    chk("copy_pc", pc_o, pc0 + 12'h001);
    chk("copy_flags", sreg_o, f);
    @(posedge clk_sys_i);
    #1 chk("copy_data", rd_data_o, REG_RST);
    $display("test register copy done");
  endtask

  // hang guard
  initial begin
    #200000;
    num_errors++;
    close_out();
  end

  // main sequence
  initial begin
    {valid_i, op_i, offset_i, dest_i, source_register_i} = '0;
    {sreg_we_i, sreg_wdata_i, rd_addr_i} = '0;
    rst_b_i    = 1'b0;
    num_errors = 0;
    n_tests    = 0;
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    #1;
    chk("rst_pc", pc_o, 12'h000);
    chk("rst_ready", ready_o, 1'b1);
    chk("rst_flags", sreg_o, SREG_RST);
    for (int p = 0; p < 6; p++) begin
      for (int o = 1; o < 18; o++) begin
        run_branch(o[4:0], pats[p], ofss[o % 3]);
      end
    end
    $display("test branch sweep done");
    run_copy();
    close_out();
  end
endmodule // test_conditional_branch_decode
`default_nettype wire
